// >>> core/ccot_core.sv
// Clock option decode, instruction cycle timing and APB status registers.
// Assumes option words come from non-volatile straps, stable at reset release.
// How it works
// - RC frequency select: 11 4 MHz, 10 8 MHz, 01 1 MHz, 00 455 kHz.
// - Output select bit puts oscillator output on shared pin in RC modes.
// - Mode field: 00 low crystal, 01 high crystal, 10 external RC, 11 internal RC.
// - External RC mode enables the RC network input pin.
// - Word two holds a 13-bit customer identifier with no effect.
// - Two set-up bits pick a stabilisation delay of 6.5 to 104 ms.
// - Each 13-bit instruction word splits into opcode and operand fields.
// - One cycle normally; writes to the program counter take two.
// - Jump, call, returns and true skips take two cycles.
// - Cycle option picks two or four oscillator clocks per cycle.
// - Timer clock is oscillator over four when four-clock cycles chosen.
// - Any bit of any register can be set, cleared or tested.
// - Port registers are handled like ordinary register operands.
// - Option words are invisible to and unchangeable by running code.
// - Cycle option is bit 10 of word zero: zero two, one four.
module ccot_core #(
  parameter int SETUP_BASE_CYC = ccot_pkg::SETUP_MIN_CYC,
  parameter int OPR_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Option words
  input wire logic [12:0] opt_word0,
  input wire logic [12:0] opt_word1,
  input wire logic [12:0] opt_word2,
  // APB slave
  input wire ccot_pkg::ccot_apb_req_t apb_req,
  output ccot_pkg::ccot_apb_rsp_t apb_rsp,
  // Decoded configuration
  output ccot_pkg::ccot_osc_cfg_t osc_cfg,
  output logic [12:0] customer_ident_field,
  output logic setup_done,
  // Cycle timing
  output logic cycle_en,
  output logic timer_tick,
  // Instruction sequencing
  input wire logic instr_valid,
  input wire logic [12:0] instr_word,
  input wire logic instr_pc_write,
  input wire logic instr_branch,
  input wire logic instr_skip_true,
  output logic instr_ready,
  output logic instr_done,
  output logic [12-OPR_W:0] opcode_field,
  output logic [OPR_W-1:0] operand_field,
  // Bit operations
  input wire logic [7:0] bit_reg_data,
  input wire logic [2:0] bit_index,
  input wire ccot_pkg::ccot_bit_op_t bit_op,
  output logic [7:0] bit_result,
  output logic bit_test,
  // Shared port pin
  input wire logic port_out,
  input wire logic port_oe,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe
);

  ccot_pkg::ccot_state_t st_reg;
  ccot_pkg::ccot_state_t st_next;
  ccot_pkg::ccot_osc_mode_t mode;
  logic cycle4;
  logic run;
  logic take;
  logic two_cycle;
  logic rc_mode;
  logic apb_setup;
  logic apb_wr;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic [13:0] irc_khz;

  // ==========================================================
  // Option decode, taken only from the captured copy
  assign mode = ccot_pkg::ccot_osc_mode_t'(
    st_reg.w1[ccot_pkg::W1_OSC_HI_BIT:ccot_pkg::W1_OSC_LO_BIT]);
  assign cycle4 = st_reg.w0[ccot_pkg::W0_CYCLE4_BIT];
  assign rc_mode = (mode == ccot_pkg::external_rc_mode) || (mode == ccot_pkg::internal_rc_mode);

  // Nominal internal RC frequency
  always_comb begin
    unique case (st_reg.w1[ccot_pkg::W1_RCF_HI_BIT:ccot_pkg::W1_RCF_LO_BIT])
      2'b11: irc_khz = ccot_pkg::IRC_KHZ_4M;
      2'b10: irc_khz = ccot_pkg::IRC_KHZ_8M;
      2'b01: irc_khz = ccot_pkg::IRC_KHZ_1M;
      2'b00: irc_khz = ccot_pkg::IRC_KHZ_455K;
    endcase
  end

  // Trim bits and unused bits are never decoded: auto calibration is assumed
  assign osc_cfg.valid = st_reg.captured;
  assign osc_cfg.irc_khz = irc_khz;
  assign osc_cfg.mode = mode;
  assign osc_cfg.rc_freq_sel = st_reg.w1[ccot_pkg::W1_RCF_HI_BIT:ccot_pkg::W1_RCF_LO_BIT];
  assign osc_cfg.out_sel = st_reg.w1[ccot_pkg::W1_OUTSEL_BIT];
  assign osc_cfg.cycle4 = cycle4;
  assign osc_cfg.rc_input_en = st_reg.captured && (mode == ccot_pkg::external_rc_mode);
  assign customer_ident_field = st_reg.w2;

  // ==========================================================
  // Stabilisation delay before anything executes
  ccot_setup_timer #(
    .BASE_CYC(SETUP_BASE_CYC)
  ) u_setup (
    .mclk(mclk),
    .reset(reset),
    .start(st_reg.captured),
    .sel(st_reg.w0[ccot_pkg::W0_SUT_HI_BIT:ccot_pkg::W0_SUT_LO_BIT]),
    .done(setup_done)
  );

  // ==========================================================
  // Cycle enables: phase wraps after two or four clocks
  assign run = st_reg.captured && setup_done;
  assign cycle_en = run && (st_reg.phase ==
    (cycle4 ? ccot_pkg::CYC4_LAST : ccot_pkg::CYC2_LAST));
  assign timer_tick = cycle_en && st_reg.tick_en;

  // Instruction hand-off only on a cycle boundary with no second cycle pending
  assign instr_ready = cycle_en && !st_reg.second;
  assign take = instr_valid && instr_ready;
  assign two_cycle = instr_pc_write || instr_branch || instr_skip_true;
  assign instr_done = st_reg.done;
  assign opcode_field = st_reg.op_word[12:OPR_W];
  assign operand_field = st_reg.op_word[OPR_W-1:0];
  assign bit_result = st_reg.bit_res;
  assign bit_test = st_reg.bit_test;

  // Shared pin: oscillator output only in the RC modes
  assign shared_port_pin_o = (rc_mode && osc_cfg.out_sel) ? st_reg.osc_out : port_out;
  assign shared_port_pin_oe = (rc_mode && osc_cfg.out_sel) ? 1'b1 : port_oe;

  // ==========================================================
  // APB decode; no register reaches the option words
  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign addr_hit = (apb_req.paddr == ccot_pkg::REG_CTRL) ||
    (apb_req.paddr == ccot_pkg::REG_STATUS) || (apb_req.paddr == ccot_pkg::REG_COUNT);
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;
  assign apb_rsp.prdata = st_reg.prdata;

  // Read mux, sampled in the setup cycle so data comes from a flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (apb_req.paddr == ccot_pkg::REG_CTRL) begin
      rd_mux[ccot_pkg::CTRL_TICK_BIT] = st_reg.tick_en;
    end else if (apb_req.paddr == ccot_pkg::REG_STATUS) begin
      rd_mux[2:0] = {st_reg.captured, st_reg.second, setup_done};
    end else if (apb_req.paddr == ccot_pkg::REG_COUNT) begin
      rd_mux[15:0] = st_reg.count;
    end
  end

  // ==========================================================
  // Next state for everything this module remembers
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    // One-time capture after reset release, then frozen
    if (!st_reg.captured) begin
      st_next.captured = 1'b1;
      st_next.w0 = opt_word0;
      st_next.w1 = opt_word1;
      st_next.w2 = opt_word2;
    end
    // Oscillator output stand-in toggles every clock, so the pin moves from capture on
    st_next.osc_out = ~st_reg.osc_out;
    if (run) begin
      st_next.phase = cycle_en ? 2'h0 : st_reg.phase + 2'h1;
    end
    // Second cycle of a long instruction, or a new fetch
    if (cycle_en && st_reg.second) begin
      st_next.second = 1'b0;
      st_next.done = 1'b1;
    end else if (take) begin
      st_next.op_word = instr_word;
      st_next.second = two_cycle;
      st_next.done = !two_cycle;
      // Source register may equally be a port register
      unique case (bit_op)
        ccot_pkg::BIT_SET: st_next.bit_res = bit_reg_data | (8'h01 << bit_index);
        ccot_pkg::BIT_CLR: st_next.bit_res = bit_reg_data & ~(8'h01 << bit_index);
        ccot_pkg::BIT_TEST: st_next.bit_test = bit_reg_data[bit_index];
        ccot_pkg::BIT_NONE: st_next.bit_res = bit_reg_data;
      endcase
    end
    // Completed instructions; a clear write wins over a completion
    if (apb_wr && apb_req.paddr == ccot_pkg::REG_CTRL && apb_req.pstrb[0]) begin
      st_next.tick_en = apb_req.pwdata[ccot_pkg::CTRL_TICK_BIT];
    end
    if (apb_wr && apb_req.paddr == ccot_pkg::REG_CTRL && apb_req.pstrb[0] &&
        apb_req.pwdata[ccot_pkg::CTRL_CLR_BIT]) begin
      st_next.count = 16'h0000;
    end else if (st_reg.done) begin
      st_next.count = st_reg.count + 16'h0001;
    end
    if (apb_setup) begin
      st_next.prdata = rd_mux;
    end
  end

  // State register; option copies rest at the erased value
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '{captured: 1'b0, w0: ccot_pkg::OPT_ERASED, w1: ccot_pkg::OPT_ERASED,
                  w2: ccot_pkg::OPT_ERASED, tick_en: ccot_pkg::CTRL_TICK_RESET, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Checks
  cyc2_rate_a: assert property (@(posedge mclk) disable iff (reset)
    (cycle_en && !cycle4) |=> !cycle_en ##1 cycle_en)
    else $error("two-clock cycle spacing wrong");

  cyc4_rate_a: assert property (@(posedge mclk) disable iff (reset)
    (cycle_en && cycle4) |=> !cycle_en [*3] ##1 cycle_en)
    else $error("four-clock cycle spacing wrong");

  timer_div_a: assert property (@(posedge mclk) disable iff (reset)
    (timer_tick && cycle4) |=> !timer_tick [*3])
    else $error("timer tick faster than oscillator over four");

  long_instr_a: assert property (@(posedge mclk) disable iff (reset)
    (take && two_cycle && !cycle4) |=> !instr_done [*2] ##1 instr_done)
    else $error("two-cycle instruction timing wrong");

  short_instr_a: assert property (@(posedge mclk) disable iff (reset)
    (take && !two_cycle) |=> instr_done)
    else $error("single-cycle instruction not done next clock");

  pin_mux_a: assert property (@(posedge mclk) disable iff (reset)
    (st_reg.captured && rc_mode && osc_cfg.out_sel) |-> shared_port_pin_oe &&
      (shared_port_pin_o != $past(shared_port_pin_o)))
    else $error("shared pin not carrying oscillator output");

  rc_input_a: assert property (@(posedge mclk) disable iff (reset)
    (st_reg.captured && !osc_cfg.rc_input_en) |-> mode != ccot_pkg::external_rc_mode)
    else $error("external RC mode without RC input");

  opts_held_a: assert property (@(posedge mclk) disable iff (reset)
    ($past(st_reg.captured) && st_reg.captured) |-> $stable(st_reg.w1) && $stable(st_reg.w0))
    else $error("option words changed while running");

  irc_freq_a: assert property (@(posedge mclk) disable iff (reset)
    (osc_cfg.rc_freq_sel == 2'b00) |-> osc_cfg.irc_khz == ccot_pkg::IRC_KHZ_455K)
    else $error("455 kHz selection decoded wrong");

  setup_gate_a: assert property (@(posedge mclk) disable iff (reset)
    !setup_done |-> !instr_ready && !cycle_en)
    else $error("execution before set-up delay ended");

  bit_set_a: assert property (@(posedge mclk) disable iff (reset)
    (take && bit_op == ccot_pkg::BIT_SET) |=> bit_result[$past(bit_index)])
    else $error("bit set did not set the chosen bit");

  long_instr4_a: assert property (@(posedge mclk) disable iff (reset)
    (take && two_cycle && cycle4) |=> !instr_done [*4] ##1 instr_done)
    else $error("two-cycle instruction timing wrong in four-clock mode");

  bit_clr_a: assert property (@(posedge mclk) disable iff (reset)
    (take && bit_op == ccot_pkg::BIT_CLR) |=> !bit_result[$past(bit_index)])
    else $error("bit clear did not clear the chosen bit");

  bit_test_a: assert property (@(posedge mclk) disable iff (reset)
    (take && bit_op == ccot_pkg::BIT_TEST && bit_reg_data[bit_index]) |=> bit_test)
    else $error("bit test missed a set bit");

  irc_4m_a: assert property (@(posedge mclk) disable iff (reset)
    (osc_cfg.rc_freq_sel == 2'b11) |-> osc_cfg.irc_khz == ccot_pkg::IRC_KHZ_4M)
    else $error("4 MHz selection decoded wrong");

  irc_8m_a: assert property (@(posedge mclk) disable iff (reset)
    (osc_cfg.rc_freq_sel == 2'b10) |-> osc_cfg.irc_khz == ccot_pkg::IRC_KHZ_8M)
    else $error("8 MHz selection decoded wrong");

  irc_1m_a: assert property (@(posedge mclk) disable iff (reset)
    (osc_cfg.rc_freq_sel == 2'b01) |-> osc_cfg.irc_khz == ccot_pkg::IRC_KHZ_1M)
    else $error("1 MHz selection decoded wrong");

  pin_port_a: assert property (@(posedge mclk) disable iff (reset)
    !(rc_mode && osc_cfg.out_sel) |-> shared_port_pin_o == port_out &&
      shared_port_pin_oe == port_oe)
    else $error("shared pin not acting as port bit");

  ident_held_a: assert property (@(posedge mclk) disable iff (reset)
    ($past(st_reg.captured) && st_reg.captured) |-> $stable(customer_ident_field))
    else $error("customer identifier changed while running");

  tick_off_a: assert property (@(posedge mclk) disable iff (reset)
    !st_reg.tick_en |-> !timer_tick)
    else $error("timer tick while disabled");

  rc_early_a: assert property (@(posedge mclk) disable iff (reset)
    !st_reg.captured |-> !osc_cfg.rc_input_en)
    else $error("RC input enabled before options captured");

endmodule

// >>> core/ccot_pkg.sv
// Shared constants, option-word field layout, enumerations and carriers
// for the clock option and cycle timing block.
// Assumes one 20 MHz clock standing in for the selected oscillator.
package ccot_pkg;

  // ==========================================================
  // Option word layout
  localparam int OPT_W = 13;
  localparam logic [12:0] OPT_ERASED = 13'h1FFF;
  localparam int W0_CYCLE4_BIT = 10;
  localparam int W0_SUT_LO_BIT = 3;
  localparam int W0_SUT_HI_BIT = 4;
  localparam int W1_OSC_LO_BIT = 1;
  localparam int W1_OSC_HI_BIT = 2;
  localparam int W1_OUTSEL_BIT = 3;
  localparam int W1_RCF_LO_BIT = 5;
  localparam int W1_RCF_HI_BIT = 6;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_MIN_US = 6500;
  localparam int SETUP_MAX_US = 104000;
  localparam int SETUP_MIN_CYC = (SETUP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CNT_W = 22;
  localparam logic [1:0] CYC2_LAST = 2'h1;
  localparam logic [1:0] CYC4_LAST = 2'h3;

  // ==========================================================
  // Nominal internal RC frequencies in kHz
  localparam logic [13:0] IRC_KHZ_4M = 14'h0FA0;
  localparam logic [13:0] IRC_KHZ_8M = 14'h1F40;
  localparam logic [13:0] IRC_KHZ_1M = 14'h03E8;
  localparam logic [13:0] IRC_KHZ_455K = 14'h01C7;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COUNT = 12'h008;
  localparam int CTRL_TICK_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_TICK_RESET = 1'b1;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    low_freq_crystal_mode = 2'b00,
    high_freq_crystal_mode = 2'b01,
    external_rc_mode = 2'b10,
    internal_rc_mode = 2'b11
  } ccot_osc_mode_t;

  typedef enum logic [1:0] {
    BIT_NONE = 2'b00,
    BIT_SET = 2'b01,
    BIT_CLR = 2'b10,
    BIT_TEST = 2'b11
  } ccot_bit_op_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ccot_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ccot_apb_rsp_t;

  typedef struct packed {
    logic valid;
    ccot_osc_mode_t mode;
    logic [1:0] rc_freq_sel;
    logic out_sel;
    logic cycle4;
    logic rc_input_en;
    logic [13:0] irc_khz;
  } ccot_osc_cfg_t;

  typedef struct packed {
    logic captured;
    logic [12:0] w0;
    logic [12:0] w1;
    logic [12:0] w2;
    logic osc_out;
    logic [1:0] phase;
    logic second;
    logic done;
    logic [12:0] op_word;
    logic [7:0] bit_res;
    logic bit_test;
    logic tick_en;
    logic [15:0] count;
    logic [31:0] prdata;
  } ccot_state_t;

  typedef struct packed {
    logic [21:0] cnt;
    logic done;
  } ccot_tmr_state_t;

endpackage

// >>> core/ccot_setup_timer.sv
// Oscillator stabilisation delay counter.
// Assumes start rises once after the option words are captured and stays.
module ccot_setup_timer #(
  parameter int BASE_CYC = ccot_pkg::SETUP_MIN_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic [1:0] sel,
  // Result
  output logic done
);

  ccot_pkg::ccot_tmr_state_t st_reg;
  ccot_pkg::ccot_tmr_state_t st_next;
  logic [21:0] target;

  // ==========================================================
  // Delay selection: 11 shortest, 00 longest, x16 span
  always_comb begin
    unique case (sel)
      2'b11: target = 22'(BASE_CYC);
      2'b10: target = 22'(BASE_CYC * 2);
      2'b01: target = 22'(BASE_CYC * 4);
      2'b00: target = 22'(BASE_CYC * 16);
    endcase
  end

  // Count up once started; done latches until reset
  always_comb begin
    st_next = st_reg;
    if (start && !st_reg.done) begin
      st_next.cnt = st_reg.cnt + 22'h000001;
      if (st_reg.cnt == target - 22'h000001) begin
        st_next.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;

endmodule

// >>> bench/ccot_pin_model.sv
// Far-side model of the shared port pad and the external RC network.
// Assumes the block's pad drive and enable come straight from ccot_core.
module ccot_pin_model (
  // Pad drive from the block
  input wire logic pin_o,
  input wire logic pin_oe,
  // Network hookup
  input wire logic rc_input_en,
  // Resolved levels
  output logic pad_level,
  output logic rc_node
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Pad resolution
  // Released pad sits at its pull-up, never at a stale value
  assign pad_level = pin_oe ? pin_o : 1'b1;

  // ==========================================================
  // RC network
  // Node swings only while the block listens on its RC input
  initial begin
    rc_node = 1'b0;
    forever begin
      #37;
      rc_node = rc_input_en ? ~rc_node : 1'b0;
    end
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the clock option and cycle timing block.
// Assumes ccot_core with zero-wait APB and the pad model beside it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  localparam int BASE = 4;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] rcf;
    logic outs;
    logic c4;
    logic [1:0] sut;
    logic [12:0] id;
    logic [13:0] khz;
    logic [4:0] mult;
  } ccot_row_t;
  ccot_row_t rows [4] = '{
    '{2'b00, 2'b11, 1'b1, 1'b0, 2'b11, 13'h0A5C, 14'h0FA0, 5'h01},
    '{2'b01, 2'b10, 1'b0, 1'b1, 2'b10, 13'h1234, 14'h1F40, 5'h02},
    '{2'b10, 2'b01, 1'b1, 1'b1, 2'b01, 13'h0001, 14'h03E8, 5'h04},
    '{2'b11, 2'b00, 1'b0, 1'b0, 2'b00, 13'h1FFE, 14'h01C7, 5'h10}};
  logic mclk, reset;
  logic [12:0] opt_word0, opt_word1, opt_word2, customer_ident_field, instr_word;
  ccot_pkg::ccot_apb_req_t apb_req;
  ccot_pkg::ccot_apb_rsp_t apb_rsp;
  ccot_pkg::ccot_osc_cfg_t osc_cfg;
  ccot_pkg::ccot_bit_op_t bit_op;
  logic setup_done, cycle_en, timer_tick, instr_valid, instr_ready, instr_done;
  logic instr_pc_write, instr_branch, instr_skip_true, bit_test, port_out, port_oe;
  logic pin_o, pin_oe, pad_level, er, a, rc_node;
  logic [4:0] opcode_field;
  logic [7:0] operand_field, bit_reg_data, bit_result;
  logic [2:0] bit_index;
  logic [31:0] rd;
  int err_count, tests_run, n, lat;

  ccot_core #(.SETUP_BASE_CYC(BASE), .OPR_W(8)) u_ccot_core (
    .mclk(mclk), .reset(reset), .opt_word0(opt_word0), .opt_word1(opt_word1),
    .opt_word2(opt_word2), .apb_req(apb_req), .apb_rsp(apb_rsp), .osc_cfg(osc_cfg),
    .customer_ident_field(customer_ident_field), .setup_done(setup_done),
    .cycle_en(cycle_en), .timer_tick(timer_tick), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc_write(instr_pc_write), .instr_branch(instr_branch),
    .instr_skip_true(instr_skip_true), .instr_ready(instr_ready), .instr_done(instr_done),
    .opcode_field(opcode_field), .operand_field(operand_field),
    .bit_reg_data(bit_reg_data), .bit_index(bit_index), .bit_op(bit_op),
    .bit_result(bit_result), .bit_test(bit_test), .port_out(port_out), .port_oe(port_oe),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe));

  ccot_pin_model u_ccot_pin_model (.pin_o(pin_o), .pin_oe(pin_oe),
    .rc_input_en(osc_cfg.rc_input_en), .pad_level(pad_level), .rc_node(rc_node));

  // ==========================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Whole run is a few hundred cycles; 20000 leaves ample margin
  initial begin
    #1000000;
    err_count++;
    tally_and_finish();
  end

  // ==========================================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, entered and left right after a rising edge
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int k;
    apb_req <= '{1'b1, 1'b0, wr, addr, wd, 4'hF};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin @(posedge mclk); k++; end while (apb_rsp.pready !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    // Idle edge so a following call never rewrites the request in this time step
    @(posedge mclk);
  endtask

  // Offer held until taken; lat counts cycles from take to done
  task run_instr(input logic [12:0] w, input logic [2:0] fl);
    int k;
    instr_valid <= 1'b1;
    instr_word <= w;
    {instr_pc_write, instr_branch, instr_skip_true} <= fl;
    k = 0;
    do begin @(negedge mclk); k++; end while (instr_ready !== 1'b1 && k < 50);
    @(posedge mclk);
    instr_valid <= 1'b0;
    {instr_pc_write, instr_branch, instr_skip_true} <= 3'b000;
    bit_op <= ccot_pkg::BIT_NONE;
    lat = 1;
    @(negedge mclk);
    while (instr_done !== 1'b1 && lat < 20) begin @(negedge mclk); lat++; end
    @(posedge mclk);
  endtask

  task bit_case(input ccot_pkg::ccot_bit_op_t op, input logic [2:0] idx,
                input logic [7:0] d, input logic [7:0] exp);
    bit_op <= op;
    bit_index <= idx;
    bit_reg_data <= d;
    run_instr(13'h0C00, 3'b000);
    if (op == ccot_pkg::BIT_TEST) check(bit_test, exp[0]);
    else check(bit_result, exp);
  endtask

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    {opt_word0, opt_word1, opt_word2} = '1;
    apb_req = '0;
    {instr_valid, instr_pc_write, instr_branch, instr_skip_true} = '0;
    instr_word = '0;
    bit_op = ccot_pkg::BIT_NONE;
    {bit_index, bit_reg_data, port_out, port_oe} = '0;
    err_count = 0;
    tests_run = 0;
    foreach (rows[i]) begin
      // Unused, trim and reserved positions stay at one
      @(posedge mclk);
      opt_word0 <= {2'b11, rows[i].c4, 5'b11111, rows[i].sut, 3'b111};
      opt_word1 <= {6'h3F, rows[i].rcf, 1'b1, rows[i].outs, rows[i].mode, 1'b1};
      opt_word2 <= rows[i].id;
      port_oe <= (i % 2 == 1);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      n = 0;
      do begin @(negedge mclk); n++; end while (setup_done !== 1'b1 && n < 200);
      check(n >= BASE * rows[i].mult && n <= BASE * rows[i].mult + 2, 1);
      // Straps change after capture; decode must not follow; unused bits stay one
      @(posedge mclk);
      opt_word1 <= opt_word1 ^ 13'h006E;
      opt_word0 <= opt_word0 ^ 13'h0418;
      repeat (3) @(posedge mclk);
      check(osc_cfg.valid, 1);
      check(osc_cfg.mode, rows[i].mode);
      check(osc_cfg.irc_khz, rows[i].khz);
      check(osc_cfg.rc_freq_sel, rows[i].rcf);
      check(osc_cfg.out_sel, rows[i].outs);
      check(osc_cfg.cycle4, rows[i].c4);
      check(osc_cfg.rc_input_en, rows[i].mode == 2'b10);
      check(customer_ident_field, rows[i].id);
      check(pin_oe, (rows[i].outs && rows[i].mode[1]) || (i % 2 == 1));
      @(negedge mclk);
      a = pad_level;
      @(negedge mclk);
      check(pad_level, (rows[i].outs && rows[i].mode[1]) ? !a : (i % 2 == 0));
      // Network node moves only in external RC mode
      a = 1'b0;
      repeat (4) begin @(negedge mclk); a |= rc_node; end
      check(a, rows[i].mode == 2'b10);
      n = 0;
      @(negedge mclk);
      while (timer_tick !== 1'b1 && n < 20) begin @(negedge mclk); n++; end
      n = 0;
      do begin @(negedge mclk); n++; end while (timer_tick !== 1'b1 && n < 20);
      check(n, rows[i].c4 ? 4 : 2);
      @(posedge mclk);
      run_instr(13'h1AC3, 3'b000);
      check(lat, 1);
      check({opcode_field, operand_field}, 13'h1AC3);
      for (int f = 0; f < 3; f++) begin
        run_instr(13'h0155, 3'b001 << f);
        check(lat, rows[i].c4 ? 5 : 3);
      end
      apb(1'b0, ccot_pkg::REG_COUNT, 32'h0);
      check(rd, 4);
      apb(1'b0, ccot_pkg::REG_STATUS, 32'h0);
      check(rd, 5);
    end
    // Register bus corner cases and bit operations
    apb(1'b0, ccot_pkg::REG_CTRL, 32'h0);
    check(rd, 1);
    apb(1'b0, 12'h0FC, 32'h0);
    check(er, 1);
    check(rd, 0);
    apb(1'b1, ccot_pkg::REG_STATUS, 32'h0);
    apb(1'b0, ccot_pkg::REG_STATUS, 32'h0);
    check(rd, 5);
    apb(1'b1, ccot_pkg::REG_CTRL, 32'h0);
    n = 0;
    repeat (8) begin @(negedge mclk); n += (timer_tick !== 1'b0); end
    check(n, 0);
    @(posedge mclk);
    apb(1'b1, ccot_pkg::REG_CTRL, 32'h3);
    apb(1'b0, ccot_pkg::REG_COUNT, 32'h0);
    check(rd, 0);
    bit_case(ccot_pkg::BIT_SET, 3'd3, 8'h00, 8'h08);
    bit_case(ccot_pkg::BIT_CLR, 3'd7, 8'hFF, 8'h7F);
    bit_case(ccot_pkg::BIT_TEST, 3'd2, 8'h04, 8'h01);
    bit_case(ccot_pkg::BIT_TEST, 3'd1, 8'hFD, 8'h00);
    tally_and_finish();
  end
endmodule
